// File: core/pois_pkg.sv
// Purpose: Shared constants and types for the power-on indicator sequencer
// Assumes: 250 MHz system clock
// Notes:   Lamp colours are encoded per lamp as a small code
package pois_pkg;

    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned DISPLAY_MS      = 3000;
    localparam int unsigned LAMP_TEST_MS    = 1000;
    localparam int unsigned FLASH_HALF_MS   = 250;
    localparam int unsigned HOLDOFF_MS      = 10000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned DISPLAY_CYC     = DISPLAY_MS * CYC_PER_MS;
    localparam int unsigned LAMP_TEST_CYC   = LAMP_TEST_MS * CYC_PER_MS;
    localparam int unsigned FLASH_HALF_CYC  = FLASH_HALF_MS * CYC_PER_MS;
    localparam int unsigned HOLDOFF_CYC     = HOLDOFF_MS * CYC_PER_MS;
    localparam int unsigned TMR_W           = 32;
    localparam int unsigned DIAG_N          = 8;
    localparam int unsigned FUNC_N          = 7;
    localparam int unsigned QUAL_W          = 3;

    // Lamp colour codes
    localparam logic [2:0] COL_OFF     = 3'h0;
    localparam logic [2:0] COL_RED     = 3'h1;
    localparam logic [2:0] COL_GREEN   = 3'h2;
    localparam logic [2:0] COL_YELLOW  = 3'h3;
    localparam logic [2:0] COL_WHITE   = 3'h4;
    localparam logic [2:0] COL_BLUE    = 3'h5;
    localparam logic [2:0] COL_YEL_GRN = 3'h6;
    localparam logic [2:0] COL_ALL     = 3'h7;

    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [1:0] CODE_ONE  = 2'h1;
    localparam logic [1:0] CODE_TWO  = 2'h2;

    localparam logic [1:0] FLASH_ONE = 2'h1;
    localparam logic [1:0] FLASH_TWO = 2'h2;

    // Function bit positions: lamp index = bit + 1
    localparam int unsigned FN_EDM   = 0;
    localparam int unsigned FN_CHAIN = 1;
    localparam int unsigned FN_CODE  = 2;

    // Live display lamp indices, diag_lamp[0] is lamp 1
    localparam int unsigned QBAR_N    = 4;
    localparam int unsigned LAMP_TOP0 = 4;
    localparam int unsigned LAMP_BOT0 = 6;

    // Phase indication {run, show, test}
    localparam logic [2:0] PHASE_TEST = 3'h1;

    typedef struct packed {
        logic       contactor_feedback_monitoring;
        logic       chaining;
        logic       restart_interlock;
        logic       muting_blanking;
        logic       reduced_resolution;
        logic       range_adjust;
        logic [1:0] beam_code;
    } pois_cfg_type;

    typedef struct packed {
        logic [2:0]              safety_output_lamp;
        logic [2:0]              field_lamp;
        logic [2:0]              end_cap_lamp;
        logic [2:0]              emitter_state_lamp;
        logic [2:0]              emitter_field_lamp;
        logic [DIAG_N-1:0][2:0]  diag_lamp;
    } pois_lamps_type;

    typedef enum logic [6:0] {
        ST_LAMP_TEST = 7'h01,
        ST_FACTORY   = 7'h02,
        ST_CONFIG    = 7'h04,
        ST_CHANGED   = 7'h08,
        ST_SHOW_CFG  = 7'h10,
        ST_RUN       = 7'h20,
        ST_BLANK     = 7'h40
    } pois_state_type;

endpackage : pois_pkg

// File: core/pois_timer.sv
// Purpose: Cycle timer with restart and terminal pulse
// Assumes: Single clock domain
// Notes:   Counts from zero to LIMIT-1 then pulses done
`timescale 1ns/10ps
`default_nettype none
module pois_timer
    import pois_pkg::*;
#(
    parameter int unsigned LIMIT = 4
)(
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    // Control
    input  wire logic i_restart,
    output logic      o_done
);
    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;
    logic             done_r;
    logic             done_nxt;

    always_comb
    begin
        done_nxt = 1'b0;
        cnt_nxt  = cnt_r + 1'b1;
        if (i_restart)
        begin
            cnt_nxt = '0;
        end
        else if (cnt_r >= TMR_W'(LIMIT - 1))
        begin
            cnt_nxt  = '0;
            done_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_done = done_r;

endmodule : pois_timer
`default_nettype wire

// File: core/pois_sequencer.sv
// Purpose: Power-on lamp sequence for emitter and receiving unit
// Assumes: Configuration and status pins are asynchronous, synchronised here
// Notes:   Lamp codes per pois_pkg; COL_ALL means every segment lit
`timescale 1ns/10ps
`default_nettype none
module pois_sequencer
    import pois_pkg::*;
#(
    parameter int unsigned DISPLAY_CYCLES = DISPLAY_CYC,
    parameter int unsigned TEST_CYCLES    = LAMP_TEST_CYC,
    parameter int unsigned FLASH_CYCLES   = FLASH_HALF_CYC,
    parameter int unsigned HOLDOFF_CYCLES = HOLDOFF_CYC
)(
    // Clock and reset
    input  wire logic           i_sys_clk,
    input  wire logic           i_reset_n,
    // Configuration and mode inputs
    input  wire pois_cfg_type   i_cfg,
    input  wire logic           i_factory_restore,
    input  wire logic           i_config_mode,
    input  wire logic           i_config_changed,
    // Live status
    input  wire logic [QUAL_W-1:0] i_align_quality,
    input  wire logic           i_top_sync,
    input  wire logic           i_bottom_sync,
    input  wire logic           i_field_clear,
    // Lamps
    output pois_lamps_type      o_lamps,
    output logic [2:0]          o_phase
);
    // Two-stage synchronisers for every pin input
    localparam int unsigned SYNC_W = $bits(pois_cfg_type) + 3 + QUAL_W + 3;
    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    pois_cfg_type      cfg;
    logic              fac_s;
    logic              cmode_s;
    logic              chg_s;
    logic [QUAL_W-1:0] qual_s;
    logic              top_s;
    logic              bot_s;
    logic              clear_s;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= {i_cfg, i_factory_restore, i_config_mode, i_config_changed,
                       i_align_quality, i_top_sync, i_bottom_sync, i_field_clear};
            sync_r <= meta_r;
        end
    end

    assign {cfg, fac_s, cmode_s, chg_s, qual_s, top_s, bot_s, clear_s} = sync_r;

    // Phase timers
    pois_state_type state_r;
    pois_state_type state_nxt;
    logic           phase_restart;
    logic           test_done;
    logic           disp_done;
    logic           flash_tick;
    logic           hold_done;
    logic           hold_restart;
    logic [2:0]     phase_r;
    logic [2:0]     phase_nxt;

    pois_timer #(.LIMIT(TEST_CYCLES)) u_test_tmr (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_restart (phase_restart),
        .o_done    (test_done)
    );
    pois_timer #(.LIMIT(DISPLAY_CYCLES)) u_disp_tmr (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_restart (phase_restart),
        .o_done    (disp_done)
    );
    pois_timer #(.LIMIT(FLASH_CYCLES)) u_flash_tmr (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_restart (phase_restart),
        .o_done    (flash_tick)
    );
    pois_timer #(.LIMIT(HOLDOFF_CYCLES)) u_hold_tmr (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_restart (hold_restart),
        .o_done    (hold_done)
    );

    // Sequence state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_LAMP_TEST:
                if (test_done)
                begin
                    if (fac_s)
                        state_nxt = ST_FACTORY;
                    else if (cmode_s)
                        state_nxt = ST_CONFIG;
                    else if (chg_s)
                        state_nxt = ST_CHANGED;
                    else
                        state_nxt = ST_SHOW_CFG;
                end
            ST_FACTORY:
                if (!fac_s)
                    state_nxt = ST_SHOW_CFG;
            ST_CONFIG:
                if (!cmode_s)
                    state_nxt = ST_SHOW_CFG;
            ST_CHANGED:
                if (disp_done)
                    state_nxt = ST_SHOW_CFG;
            ST_SHOW_CFG:
                if (disp_done)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (hold_done)
                    state_nxt = ST_BLANK;
            ST_BLANK:
                if (!clear_s)
                    state_nxt = ST_RUN;
            default:
                state_nxt = ST_LAMP_TEST;
        endcase
        phase_nxt = {(state_nxt == ST_RUN) || (state_nxt == ST_BLANK), state_nxt == ST_SHOW_CFG,
                     state_nxt == ST_LAMP_TEST};
    end
    assign phase_restart = (state_nxt != state_r);
    assign hold_restart  = (state_r != ST_RUN) || !clear_s;

    // Flash phase and flash counter for beam code
    logic       blink_r;
    logic       blink_nxt;
    logic [1:0] flashes_r;
    logic [1:0] flashes_nxt;

    always_comb
    begin
        blink_nxt   = blink_r;
        flashes_nxt = flashes_r;
        if (phase_restart)
        begin
            blink_nxt   = 1'b0;
            flashes_nxt = '0;
        end
        else if (flash_tick)
        begin
            blink_nxt = !blink_r;
            if (blink_r && flashes_r != FLASH_TWO)
                flashes_nxt = flashes_r + 1'b1;
        end
    end
    // Beam code flashes are counted on falling edge of blink
    function automatic logic code_flash_on(input logic [1:0] code, input logic [1:0] done_n, input logic bl);
        code_flash_on = bl && (code != CODE_NONE) && (done_n < code);
    endfunction : code_flash_on

    // Lamp pattern
    pois_lamps_type lamps_nxt;
    pois_lamps_type lamps_r;
    logic [FUNC_N-1:0] fn_vec;

    assign fn_vec = {cfg.range_adjust, cfg.reduced_resolution, cfg.muting_blanking,
                     cfg.restart_interlock, (cfg.beam_code != CODE_NONE), cfg.chaining,
                     cfg.contactor_feedback_monitoring};

    always_comb
    begin
        lamps_nxt = '0;
        case (state_r)
            ST_LAMP_TEST:
                lamps_nxt = '1;
            ST_FACTORY:
            begin
                lamps_nxt.safety_output_lamp = COL_RED;
                lamps_nxt.field_lamp         = COL_YEL_GRN;
                lamps_nxt.end_cap_lamp       = COL_YEL_GRN;
                lamps_nxt.emitter_state_lamp = COL_RED;
                lamps_nxt.emitter_field_lamp = COL_YEL_GRN;
            end
            ST_CONFIG:
            begin
                lamps_nxt.safety_output_lamp = COL_RED;
                lamps_nxt.field_lamp         = COL_GREEN;
                lamps_nxt.end_cap_lamp       = COL_GREEN;
                lamps_nxt.emitter_state_lamp = COL_RED;
                lamps_nxt.emitter_field_lamp = COL_GREEN;
                for (int i = 0; i < FUNC_N; i++)
                    lamps_nxt.diag_lamp[i] = (fn_vec[i] && blink_r) ? COL_WHITE : COL_OFF;
            end
            ST_CHANGED:
            begin
                for (int i = 0; i < DIAG_N; i++)
                    lamps_nxt.diag_lamp[i] = blink_r ? COL_WHITE : COL_OFF;
            end
            ST_SHOW_CFG:
            begin
                for (int i = 0; i < FUNC_N; i++)
                    lamps_nxt.diag_lamp[i] = fn_vec[i] ? COL_WHITE : COL_OFF;
                if (code_flash_on(cfg.beam_code, flashes_r, blink_r))
                begin
                    lamps_nxt.field_lamp         = COL_YELLOW;
                    lamps_nxt.end_cap_lamp       = COL_YELLOW;
                    lamps_nxt.emitter_field_lamp = COL_YELLOW;
                end
            end
            ST_RUN, ST_BLANK:
            begin
                if (state_r == ST_RUN)
                    for (int i = 0; i < QBAR_N; i++)
                        lamps_nxt.diag_lamp[i] = (qual_s > QUAL_W'(i)) ? COL_BLUE : COL_OFF;
                for (int i = LAMP_TOP0; i < DIAG_N; i++)
                    lamps_nxt.diag_lamp[i] = ((i < LAMP_BOT0) ? top_s : bot_s) ? COL_BLUE : COL_OFF;
            end
            default:
                lamps_nxt = '0;
        endcase
    end
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_r   <= ST_LAMP_TEST;
            phase_r   <= PHASE_TEST;
            blink_r   <= 1'b0;
            flashes_r <= '0;
            lamps_r   <= '0;
        end
        else
        begin
            state_r   <= state_nxt;
            phase_r   <= phase_nxt;
            blink_r   <= blink_nxt;
            flashes_r <= flashes_nxt;
            lamps_r   <= lamps_nxt;
        end
    end

    assign o_lamps = lamps_r;
    assign o_phase = phase_r;
    // Assertions
    a_test_first: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == ST_LAMP_TEST) |=> (lamps_r == '1) || (state_r != ST_LAMP_TEST))
        else $error("lamp test pattern missing");
    a_show_to_run: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == ST_RUN) |-> $past(state_r) inside {ST_SHOW_CFG, ST_RUN, ST_BLANK})
        else $error("run entered without configuration display");
    a_flash_cap: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == ST_SHOW_CFG && cfg.beam_code == CODE_ONE && flashes_r >= FLASH_ONE)
        |=> lamps_r.field_lamp != COL_YELLOW)
        else $error("code one flashed more than once");
    a_flash_two: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (cfg.beam_code == CODE_TWO && flashes_r == FLASH_TWO) |=> lamps_r.field_lamp != COL_YELLOW)
        else $error("code two flashed more than twice");
    a_func_white: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == ST_SHOW_CFG && fn_vec[FN_EDM]) |=> lamps_r.diag_lamp[FN_EDM] == COL_WHITE)
        else $error("monitoring lamp not white");
    a_factory_pat: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == ST_FACTORY) |=> (lamps_r.safety_output_lamp == COL_RED) && (lamps_r.diag_lamp == '0))
        else $error("factory pattern wrong");
    a_config_pat: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == ST_CONFIG) |=> (lamps_r.field_lamp == COL_GREEN))
        else $error("config pattern wrong");
    a_quality_bar: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == ST_RUN && qual_s == '0) |=> lamps_r.diag_lamp[0] == COL_OFF)
        else $error("quality bar lit without quality");
    a_top_sync: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == ST_RUN && top_s) |=> lamps_r.diag_lamp[LAMP_TOP0] == COL_BLUE)
        else $error("top beam lamp off");
    a_blank_clear: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_r == ST_BLANK) |=> lamps_r.diag_lamp[0] == COL_OFF)
        else $error("quality bar not blanked");

endmodule : pois_sequencer
`default_nettype wire

// File: bench/power_on_indicator_sequencer_test.sv
// Purpose: Self-checking bench for the power-on lamp sequence
// Assumes: Shortened display, test, flash and holdoff counts
// Notes:   Inputs change and lamps are sampled on the falling edge
`timescale 1ns/10ps
`default_nettype none
module power_on_indicator_sequencer_test;
    import pois_pkg::*;

    localparam int unsigned DISP = 40;
    localparam int unsigned TEST = 20;
    localparam int unsigned FLSH = 4;
    localparam int unsigned HOLD = 30;

    logic              i_sys_clk         = 1'b0;
    logic              i_reset_n         = 1'b0;
    pois_cfg_type      i_cfg             = '0;
    logic              i_factory_restore = 1'b0;
    logic              i_config_mode     = 1'b0;
    logic              i_config_changed  = 1'b0;
    logic [QUAL_W-1:0] i_align_quality   = '0;
    logic              i_top_sync        = 1'b0;
    logic              i_bottom_sync     = 1'b0;
    logic              i_field_clear     = 1'b0;
    pois_lamps_type    o_lamps;
    logic [2:0]        o_phase;
    int                failures          = 0;
    int                n_tests           = 0;
    int                n;
    int                k;
    logic [2:0]        seen;

    always #2 i_sys_clk = ~i_sys_clk;

    pois_sequencer #(
        .DISPLAY_CYCLES (DISP),
        .TEST_CYCLES    (TEST),
        .FLASH_CYCLES   (FLSH),
        .HOLDOFF_CYCLES (HOLD)
    ) dut_u (
        .i_sys_clk         (i_sys_clk),
        .i_reset_n         (i_reset_n),
        .i_cfg             (i_cfg),
        .i_factory_restore (i_factory_restore),
        .i_config_mode     (i_config_mode),
        .i_config_changed  (i_config_changed),
        .i_align_quality   (i_align_quality),
        .i_top_sync        (i_top_sync),
        .i_bottom_sync     (i_bottom_sync),
        .i_field_clear     (i_field_clear),
        .o_lamps           (o_lamps),
        .o_phase           (o_phase)
    );

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check

    task automatic cycles(input int c);
        repeat (c) @(negedge i_sys_clk);
    endtask : cycles

    task automatic wait_phase(input logic [2:0] p, input int bound, output int cyc);
        cyc = 0;
        while (o_phase !== p && cyc <= bound)
        begin
            @(negedge i_sys_clk);
            cyc++;
        end
        if (cyc > bound)
        begin
            check("phase_wait", o_phase, p);
            print_verdict();
        end
    endtask : wait_phase

    function automatic logic [23:0] cfg_diag(input pois_cfg_type c);
        logic [7:0] on;
        on = {1'b0, c.range_adjust, c.reduced_resolution, c.muting_blanking, c.restart_interlock,
              c.beam_code != 2'h0, c.chaining, c.contactor_feedback_monitoring};
        cfg_diag = '0;
        for (int i = 0; i < 8; i++)
            cfg_diag[i*3 +: 3] = on[i] ? COL_WHITE : COL_OFF;
    endfunction : cfg_diag

    function automatic logic [23:0] run_diag(input logic [2:0] q, input logic t, input logic b);
        run_diag = '0;
        for (int i = 0; i < 8; i++)
            run_diag[i*3 +: 3] = ((i < 4 && i < q) || (i inside {4, 5} && t) || (i > 5 && b)) ? COL_BLUE : COL_OFF;
    endfunction : run_diag

    // Each start is a fresh power-on, also from the middle of a run
    task automatic do_reset(input logic fac, input logic cm, input logic chg, input logic [1:0] bc);
        @(negedge i_sys_clk);
        i_reset_n = 1'b0;
        i_factory_restore = fac;
        i_config_mode = cm;
        i_config_changed = chg;
        i_cfg = pois_cfg_type'(9'($urandom()));
        i_cfg.beam_code = bc;
        cycles(12);
        check("lamps_in_reset", o_lamps, '0);
        i_reset_n = 1'b1;
        cycles(3);
        check("lamp_test", o_lamps, {13{COL_ALL}});
        check("phase_test", o_phase, 3'h1);
    endtask : do_reset

    // Caller has seen the configuration phase begin
    task automatic show_check();
        int         len;
        int         fl[3];
        logic [2:0] pv[3];
        logic [2:0] lm[3];
        len = 0;
        fl = '{0, 0, 0};
        pv = '{COL_OFF, COL_OFF, COL_OFF};
        while (o_phase === 3'h2 && len < DISP + 8)
        begin
            if (len == DISP / 2)
                check("cfg_diag", o_lamps.diag_lamp, cfg_diag(i_cfg));
            lm = '{o_lamps.field_lamp, o_lamps.end_cap_lamp, o_lamps.emitter_field_lamp};
            for (int i = 0; i < 3; i++)
            begin
                if (lm[i] === COL_YELLOW && pv[i] !== COL_YELLOW)
                    fl[i]++;
                pv[i] = lm[i];
            end
            cycles(1);
            len++;
        end
        check("cfg_len", len + 3 >= DISP && len <= DISP + 3, 1'b1);
        for (int i = 0; i < 3; i++)
            check("flash_count", fl[i], i_cfg.beam_code);
        wait_phase(3'h4, 4, len);
    endtask : show_check

    initial
    begin
        repeat (100000) @(posedge i_sys_clk);
        failures++;
        print_verdict();
    end

    initial
    begin
        k = $urandom(32'h09047ee5);
        do_reset(1'b0, 1'b0, 1'b0, 2'h1);
        wait_phase(3'h2, TEST + 8, n);
        check("test_len", n + 6 >= TEST && n <= TEST + 3, 1'b1);
        show_check();
        // Corners 0 and 4 first, then random bars and sync
        for (int i = 0; i < 12; i++)
        begin
            i_align_quality = (i < 2) ? 3'(i * 4) : 3'($urandom_range(4, 0));
            i_top_sync = 1'($urandom());
            i_bottom_sync = 1'($urandom());
            cycles(5);
            check("run_diag", o_lamps.diag_lamp, run_diag(i_align_quality, i_top_sync, i_bottom_sync));
        end
        i_align_quality = 3'h4;
        i_field_clear = 1'b1;
        cycles(HOLD / 2);
        check("holdoff_early", o_lamps.diag_lamp[3:0], {4{COL_BLUE}});
        cycles(HOLD);
        check("holdoff_blank", o_lamps.diag_lamp[3:0], 12'h000);
        i_field_clear = 1'b0;
        cycles(6);
        check("unblank", o_lamps.diag_lamp[3:0], {4{COL_BLUE}});
        do_reset(1'b1, 1'b0, 1'b0, 2'h2);
        // Factory pattern only once the lamp test is over
        wait_phase(3'h0, TEST + 8, n);
        for (int i = 0; i < 2; i++)
        begin
            cycles(TEST / 2 + 4);
            check("factory", o_lamps, {COL_RED, COL_YEL_GRN, COL_YEL_GRN, COL_RED, COL_YEL_GRN, 24'h000000});
        end
        i_factory_restore = 1'b0;
        wait_phase(3'h2, 8, n);
        show_check();
        do_reset(1'b0, 1'b1, 1'b0, 2'h0);
        i_cfg.contactor_feedback_monitoring = 1'b1;
        i_cfg.chaining = 1'b0;
        cycles(TEST + 4);
        check("cfg_mode", {o_lamps.safety_output_lamp, o_lamps.field_lamp, o_lamps.end_cap_lamp,
              o_lamps.emitter_state_lamp, o_lamps.emitter_field_lamp},
              {COL_RED, COL_GREEN, COL_GREEN, COL_RED, COL_GREEN});
        seen = '0;
        repeat (4 * FLSH)
        begin
            seen[0] |= (o_lamps.diag_lamp[0] !== COL_OFF);
            seen[1] |= (o_lamps.diag_lamp[0] === COL_OFF);
            seen[2] |= (o_lamps.diag_lamp[1] !== COL_OFF);
            cycles(1);
        end
        check("cfg_flash", seen[2:0], 3'h3);
        i_config_mode = 1'b0;
        wait_phase(3'h2, 8, n);
        show_check();
        do_reset(1'b0, 1'b0, 1'b1, 2'h2);
        cycles(TEST + 4);
        seen = '0;
        repeat (DISP - 8)
        begin
            seen[0] |= (o_lamps.diag_lamp[2] === COL_WHITE);
            seen[1] |= (o_lamps.diag_lamp[2] === COL_OFF);
            seen[2] |= (o_phase === 3'h2);
            cycles(1);
        end
        check("changed_flash", seen[2:0], 3'h3);
        i_config_changed = 1'b0;
        wait_phase(3'h2, 16, n);
        show_check();
        print_verdict();
    end

endmodule : power_on_indicator_sequencer_test
`default_nettype wire
